// ==== flash_status_pkg.sv ====
/*
  constants of the status block: opcodes, field positions, reset values.
  assumes a byte-wide spi instruction stream, msb first.
*/
package flash_status_pkg;

  // instruction codes seen on the serial link
  localparam logic [7:0] OP_NONE            = 8'h00;
  localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
  localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
  localparam logic [7:0] OP_WRITE_SR1       = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2       = 8'h31;
  localparam logic [7:0] OP_WRITE_SR3       = 8'h11;
  localparam logic [7:0] OP_READ_SR1        = 8'h05;
  localparam logic [7:0] OP_READ_SR2        = 8'h35;
  localparam logic [7:0] OP_READ_SR3        = 8'h15;
  localparam logic [7:0] OP_SUSPEND         = 8'h75;
  localparam logic [7:0] OP_RESUME          = 8'h7A;
  localparam logic [7:0] OP_ENTER_WIDE      = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE       = 8'hE9;
  localparam logic [7:0] OP_PERMANENT_LOCK  = 8'h6F; // arbitrary code

  // status register one layout
  localparam int LATCH_POS  = 1;
  localparam int LEVEL_LSB  = 2;
  localparam int LEVEL_W    = 4;
  localparam int TB_POS     = 6;
  // status register two layout
  localparam int LOCK_POS   = 0;
  localparam int SECLK_LSB  = 3;
  localparam int SECLK_W    = 3;
  localparam int CMP_POS    = 6;
  localparam int PAUSE_POS  = 7;
  // status register three layout
  localparam int CUR_POS    = 0;
  localparam int PUP_POS    = 1;
  localparam int SCHEME_POS = 2;
  localparam int DRIVE_LSB  = 5;
  localparam int DRIVE_W    = 2;

  // reset values
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [2:0] SECLK_RESET = 3'h0;
  localparam logic [1:0] DRIVE_RESET = 2'h3;

  // protection decode
  localparam int         BLOCK_W     = 9;
  localparam int         COUNT_W     = 10;
  localparam logic [3:0] LEVEL_ONE   = 4'h1;
  localparam logic [3:0] LEVEL_FULL  = 4'hA;
  localparam logic [9:0] BLOCK_TOTAL = 10'h200;
  localparam logic [9:0] COUNT_ONE   = 10'h001;

  // link byte framing
  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam logic [1:0] INDEX_MAX   = 2'h3;
  localparam logic [1:0] INDEX_ONE   = 2'h1;
  localparam logic [1:0] INDEX_TWO   = 2'h2;

endpackage : flash_status_pkg

// ==== status_sync_bit.sv ====
/*
  two flip-flop synchroniser for one level.
  assumes the input changes no faster than two destination clocks.
*/
`timescale 1ns/1ns
module status_sync_bit #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);

  logic stage; // first stage, read only by dout

  // plain two-stage shift
  always_ff @(posedge clock) begin
    if (reset) begin
      stage <= RESET_VALUE;
      dout  <= RESET_VALUE;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end

endmodule : status_sync_bit

// ==== spi_status_link.sv ====
/*
  serial-clock side: bytes in, a toggle per byte to the core, status out.
  assumes spi mode 0 and status shadows held still during a frame.
*/
`timescale 1ns/1ns
module spi_status_link
  import flash_status_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       reset,
  input  wire logic       mosi,
  input  wire logic [7:0] shadowOne,
  input  wire logic [7:0] shadowTwo,
  input  wire logic [7:0] shadowThree,
  output logic            byteToggle,
  output logic [7:0]      opcode,
  output logic [7:0]      dataByte,
  output logic [1:0]      byteIndex,
  output logic            miso,
  output logic            misoOe
);

  logic [2:0] bitCount, next_bitCount;     // bit within byte
  logic [6:0] shiftIn, next_shiftIn;       // bits gathered so far
  logic [1:0] byteCount, next_byteCount;   // bytes done this frame
  logic [7:0] next_opcode, next_dataByte;
  logic [1:0] next_byteIndex;
  logic       next_byteToggle;
  logic [7:0] outShift, next_outShift;     // outgoing status byte
  logic       next_misoOe;
  logic [7:0] fullByte;                    // byte completed this edge
  logic       readActive;                  // read opcode seen

  // receive path next values
  always_comb begin
    fullByte        = {shiftIn, mosi};
    next_shiftIn    = fullByte[6:0];
    next_bitCount   = bitCount + 3'h1;
    next_byteCount  = byteCount;
    next_opcode     = opcode;
    next_dataByte   = dataByte;
    next_byteIndex  = byteIndex;
    next_byteToggle = byteToggle;
    if (bitCount == LAST_BIT) begin
      // byte complete: publish and flip the toggle on the same edge
      if (byteCount == 2'h0) begin
        next_opcode = fullByte;
      end else begin
        next_dataByte = fullByte;
      end
      next_byteIndex  = byteCount;
      next_byteToggle = ~byteToggle;
      if (byteCount != INDEX_MAX) begin
        next_byteCount = byteCount + 2'h1;
      end
    end
  end

  // frame-scoped counters, cleared by chip select
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCount  <= 3'h0;
      shiftIn   <= 7'h00;
      byteCount <= 2'h0;
    end else begin
      bitCount  <= next_bitCount;
      shiftIn   <= next_shiftIn;
      byteCount <= next_byteCount;
    end
  end

  // handed-over words survive the frame end for the core
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      opcode     <= OP_NONE;
      dataByte   <= 8'h00;
      byteIndex  <= 2'h0;
      byteToggle <= 1'b0;
    end else begin
      opcode     <= next_opcode;
      dataByte   <= next_dataByte;
      byteIndex  <= next_byteIndex;
      byteToggle <= next_byteToggle;
    end
  end

  // transmit path: reload at each byte boundary, else shift
  always_comb begin
    readActive = (byteCount != 2'h0) &&
                 ((opcode == OP_READ_SR1) || (opcode == OP_READ_SR2) ||
                  (opcode == OP_READ_SR3));
    next_misoOe = readActive;
    if (bitCount == 3'h0) begin
      unique case (opcode)
        OP_READ_SR2: next_outShift = shadowTwo;
        OP_READ_SR3: next_outShift = shadowThree;
        default:     next_outShift = shadowOne;
      endcase
    end else begin
      next_outShift = {outShift[6:0], 1'b0};
    end
  end

  // falling-edge output stage
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      outShift <= 8'h00;
      misoOe   <= 1'b0;
    end else begin
      outShift <= next_outShift;
      misoOe   <= next_misoOe;
    end
  end

  assign miso = outShift[7];

endmodule : spi_status_link

// ==== flash_status_protect_regs.sv ====
/*
  status, lock and configuration bits of one flash die plus the range check.
  assumes idle chip select >= 3 core clocks and sclk below clock/3.
*/
`timescale 1ns/1ns

// Contract
// - four-bit protect level, written by write-status
// - protect level resets to zero, nothing protected
// - top/bottom select picks region end, default top
// - top/bottom written only when lock and latch allow
// - complement bit inverts the chosen region
// - status lock blocks all status writes until power
// - volatile lock plus permanent one-time lock
// - suspend flag set by 75h, cleared by 7Ah
// - three security locks, set-only, default zero
// - current width bit shows three or four bytes
// - power-up width bit written only after 06h
// - power-up width bit picks starting address mode; reset also clears the bit, so start is three bytes
// - scheme bit chooses region or per-block locks
// - per-block locks all set after reset
// - two-bit drive strength code, default 11
// - reserved bits ignore writes, read zero
// - protection covers all, none or part
// - request touching protected blocks is rejected whole
module flash_status_protect_regs (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               sclk,
  input  wire logic               csN,
  input  wire logic               mosi,
  output logic                    miso,
  output logic                    misoOe,
  input  wire logic               chkValid,
  input  wire logic [8:0]         chkFirst,
  input  wire logic [8:0]         chkLast,
  output logic                    chkDone,
  output logic                    chkReject,
  output logic [3:0]              protectLevel,
  output logic                    topBottomSelect,
  output logic                    complementProtect,
  output logic                    statusWriteLock,
  output logic                    pausedOpFlag,
  output logic [2:0]              securityLocks,
  output logic                    currentAddrWidth,
  output logic                    powerupAddrWidth,
  output logic                    protectSchemeSelect,
  output logic [1:0]              outputStrength,
  output logic                    writeLatch
);
  import flash_status_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_FRAME, S_EXEC} state_t;

  state_t     state, next_state;         // frame tracker
  logic [7:0] curOp, next_curOp;         // opcode of open frame
  logic [7:0] d1, next_d1;               // first data byte
  logic [7:0] d2, next_d2;               // second data byte
  logic [1:0] dataCount, next_dataCount; // data bytes seen
  logic       togPrev, next_togPrev;     // last toggle consumed
  logic       initPending, next_initPending;
  logic       volatileOk, next_volatileOk; // volatile write enable
  logic       otpLock, next_otpLock;       // permanent status lock
  logic       blockLocks, next_blockLocks; // per-block locks, all set
  logic [3:0] next_protectLevel;
  logic       next_topBottomSelect, next_complementProtect;
  logic       next_statusWriteLock, next_pausedOpFlag;
  logic [2:0] next_securityLocks;
  logic       next_currentAddrWidth, next_powerupAddrWidth;
  logic       next_protectSchemeSelect, next_writeLatch;
  logic [1:0] next_outputStrength;
  logic [7:0] shadowOne, shadowTwo, shadowThree; // held for the link
  logic [7:0] next_shadowOne, next_shadowTwo, next_shadowThree;
  logic       next_chkDone, next_chkReject;

  logic       csIdle;       // synchronised chip select, high = idle
  logic       togSeen;      // synchronised byte toggle
  logic       linkToggle;   // link-domain toggle
  logic [7:0] linkOpcode, linkData;
  logic [1:0] linkIndex;
  logic       allowWrite;   // lock and latch permit status writes
  logic       sr2Go;        // second status byte is to be applied
  logic [7:0] sr2Byte;      // source of second status byte

  logic [9:0] regionCount, regionLo, regionHi; // protected span
  logic [9:0] firstWide, lastWide;
  logic       regionHit, regionInside;

  // serial-clock side
  spi_status_link link (.sclk(sclk), .csN(csN), .reset(reset), .mosi(mosi), .shadowOne(shadowOne),
    .shadowTwo(shadowTwo), .shadowThree(shadowThree), .byteToggle(linkToggle), .opcode(linkOpcode),
    .dataByte(linkData), .byteIndex(linkIndex), .miso(miso), .misoOe(misoOe));

  // chip select into the core clock
  status_sync_bit #(.RESET_VALUE(1'b1)) csSync (.clock(clock), .reset(reset), .din(csN), .dout(csIdle));

  // byte event toggle into the core clock
  status_sync_bit #(.RESET_VALUE(1'b0)) togSync (.clock(clock), .reset(reset), .din(linkToggle), .dout(togSeen));

  // instruction decode and register next values
  always_comb begin
    next_state               = state;
    next_curOp               = curOp;
    next_d1                  = d1;
    next_d2                  = d2;
    next_dataCount           = dataCount;
    next_togPrev             = togSeen;
    next_initPending         = 1'b0;
    next_volatileOk          = volatileOk;
    next_otpLock             = otpLock;
    next_blockLocks          = blockLocks;
    next_protectLevel        = protectLevel;
    next_topBottomSelect     = topBottomSelect;
    next_complementProtect   = complementProtect;
    next_statusWriteLock     = statusWriteLock;
    next_pausedOpFlag        = pausedOpFlag;
    next_securityLocks       = securityLocks;
    next_currentAddrWidth    = currentAddrWidth;
    next_powerupAddrWidth    = powerupAddrWidth;
    next_protectSchemeSelect = protectSchemeSelect;
    next_outputStrength      = outputStrength;
    next_writeLatch          = writeLatch;

    // the status lock or the permanent lock closes the status registers to writes
    allowWrite = (writeLatch | volatileOk) & ~statusWriteLock & ~otpLock;
    sr2Byte    = (curOp == OP_WRITE_SR1) ? d2 : d1;
    sr2Go      = allowWrite &&
                 (((curOp == OP_WRITE_SR1) && (dataCount == INDEX_TWO)) ||
                  ((curOp == OP_WRITE_SR2) && (dataCount != 2'h0)));

    // start-up address mode follows the power-up width bit
    if (initPending) begin
      next_currentAddrWidth = powerupAddrWidth;
    end

    // byte handed over by the link
    if (togSeen != togPrev) begin
      if (linkIndex == 2'h0) begin
        next_curOp = linkOpcode;
      end else if (linkIndex == INDEX_ONE) begin
        next_d1        = linkData;
        next_dataCount = INDEX_ONE;
      end else if (linkIndex == INDEX_TWO) begin
        next_d2        = linkData;
        next_dataCount = INDEX_TWO;
      end
    end

    unique case (state)
      S_IDLE: begin
        // new frame opens
        if (!csIdle) begin
          next_state     = S_FRAME;
          next_curOp     = OP_NONE;
          next_dataCount = 2'h0;
        end
      end
      S_FRAME: begin
        // one spare cycle lets a late last byte land
        if (csIdle) begin
          next_state = S_EXEC;
        end
      end
      S_EXEC: begin
        next_state = S_IDLE;
        unique case (curOp)
          OP_WRITE_ENABLE: begin
            next_writeLatch = 1'b1;
            next_volatileOk = 1'b0;
          end
          OP_VOLATILE_ENABLE: begin
            next_volatileOk = 1'b1;
          end
          OP_WRITE_DISABLE: begin
            next_writeLatch = 1'b0;
            next_volatileOk = 1'b0;
          end
          OP_WRITE_SR1, OP_WRITE_SR2: begin
            if (allowWrite && (curOp == OP_WRITE_SR1) && (dataCount != 2'h0)) begin
              next_protectLevel    = d1[LEVEL_LSB +: LEVEL_W];
              next_topBottomSelect = d1[TB_POS];
            end
            if (sr2Go) begin
              next_statusWriteLock   = sr2Byte[LOCK_POS];
              next_complementProtect = sr2Byte[CMP_POS];
              // one-time bits only ever set
              next_securityLocks = securityLocks |
                                   sr2Byte[SECLK_LSB +: SECLK_W];
            end
            if (allowWrite) begin
              next_writeLatch = 1'b0;
              next_volatileOk = 1'b0;
            end
          end
          OP_WRITE_SR3: begin
            if (allowWrite && (dataCount != 2'h0)) begin
              next_protectSchemeSelect = d1[SCHEME_POS];
              next_outputStrength      = d1[DRIVE_LSB +: DRIVE_W];
              // non-volatile bit only after write enable
              if (writeLatch) begin
                next_powerupAddrWidth = d1[PUP_POS];
              end
              next_writeLatch = 1'b0;
              next_volatileOk = 1'b0;
            end
          end
          OP_PERMANENT_LOCK: begin
            // permanent status lock, needs write enable
            if (allowWrite && writeLatch) begin
              next_otpLock    = 1'b1;
              next_writeLatch = 1'b0;
            end
          end
          OP_SUSPEND: next_pausedOpFlag = 1'b1;
          OP_RESUME:  next_pausedOpFlag = 1'b0;
          OP_ENTER_WIDE: next_currentAddrWidth = 1'b1;
          OP_EXIT_WIDE:  next_currentAddrWidth = 1'b0;
          default: begin
            // reads and unknown codes change nothing
          end
        endcase
      end
      default: next_state = S_IDLE;
    endcase
  end

  // status images for the link, refreshed only between frames
  always_comb begin
    next_shadowOne   = shadowOne;
    next_shadowTwo   = shadowTwo;
    next_shadowThree = shadowThree;
    if ((state == S_IDLE) && csIdle) begin
      // reserved positions stay zero
      next_shadowOne   = 8'h00;
      next_shadowTwo   = 8'h00;
      next_shadowThree = 8'h00;
      next_shadowOne[LATCH_POS]                   = writeLatch;
      next_shadowOne[LEVEL_LSB +: LEVEL_W]        = protectLevel;
      next_shadowOne[TB_POS]                      = topBottomSelect;
      next_shadowTwo[LOCK_POS]                    = statusWriteLock | otpLock;
      next_shadowTwo[SECLK_LSB +: SECLK_W]        = securityLocks;
      next_shadowTwo[CMP_POS]                     = complementProtect;
      next_shadowTwo[PAUSE_POS]                   = pausedOpFlag;
      next_shadowThree[CUR_POS]                   = currentAddrWidth;
      next_shadowThree[PUP_POS]                   = powerupAddrWidth;
      next_shadowThree[SCHEME_POS]                = protectSchemeSelect;
      next_shadowThree[DRIVE_LSB +: DRIVE_W]      = outputStrength;
    end
  end

  // protected span from level, end select and complement
  always_comb begin
    if (protectLevel == LEVEL_RESET) begin
      regionCount = 10'h000;
    end else if (protectLevel >= LEVEL_FULL) begin
      regionCount = BLOCK_TOTAL;
    end else begin
      regionCount = COUNT_ONE << (protectLevel - LEVEL_ONE);
    end
    // top when clear, bottom when set
    regionLo     = topBottomSelect ? 10'h000 : (BLOCK_TOTAL - regionCount);
    regionHi     = topBottomSelect ? (regionCount - COUNT_ONE) : (BLOCK_TOTAL - COUNT_ONE);
    firstWide    = {1'b0, chkFirst};
    lastWide     = {1'b0, chkLast};
    regionHit    = (regionCount != 10'h000) && (firstWide <= regionHi) && (lastWide >= regionLo);
    regionInside = (regionCount != 10'h000) && (firstWide >= regionLo) && (lastWide <= regionHi);
    next_chkDone = chkValid;
    if (protectSchemeSelect) begin
      next_chkReject = chkValid & blockLocks;
    end else if (complementProtect) begin
      next_chkReject = chkValid & ~regionInside;
    end else begin
      next_chkReject = chkValid & regionHit;
    end
  end

  // register stage
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= S_IDLE;
      curOp <= OP_NONE;
      d1 <= 8'h00;
      d2 <= 8'h00;
      dataCount <= 2'h0;
      togPrev <= 1'b0;
      initPending <= 1'b1;
      volatileOk <= 1'b0;
      otpLock <= 1'b0;
      blockLocks <= 1'b1;
      protectLevel <= LEVEL_RESET;
      topBottomSelect <= 1'b0;
      complementProtect <= 1'b0;
      statusWriteLock <= 1'b0;
      pausedOpFlag <= 1'b0;
      securityLocks <= SECLK_RESET;
      currentAddrWidth <= 1'b0;
      powerupAddrWidth <= 1'b0;
      protectSchemeSelect <= 1'b0;
      outputStrength <= DRIVE_RESET;
      writeLatch <= 1'b0;
      shadowOne <= 8'h00;
      shadowTwo <= 8'h00;
      shadowThree <= 8'h00;
      chkDone <= 1'b0;
      chkReject <= 1'b0;
    end else begin
      state <= next_state;
      curOp <= next_curOp;
      d1 <= next_d1;
      d2 <= next_d2;
      dataCount <= next_dataCount;
      togPrev <= next_togPrev;
      initPending <= next_initPending;
      volatileOk <= next_volatileOk;
      otpLock <= next_otpLock;
      blockLocks <= next_blockLocks;
      protectLevel <= next_protectLevel;
      topBottomSelect <= next_topBottomSelect;
      complementProtect <= next_complementProtect;
      statusWriteLock <= next_statusWriteLock;
      pausedOpFlag <= next_pausedOpFlag;
      securityLocks <= next_securityLocks;
      currentAddrWidth <= next_currentAddrWidth;
      powerupAddrWidth <= next_powerupAddrWidth;
      protectSchemeSelect <= next_protectSchemeSelect;
      outputStrength <= next_outputStrength;
      writeLatch <= next_writeLatch;
      shadowOne <= next_shadowOne;
      shadowTwo <= next_shadowTwo;
      shadowThree <= next_shadowThree;
      chkDone <= next_chkDone;
      chkReject <= next_chkReject;
    end
  end

endmodule : flash_status_protect_regs

// ==== flash_status_checker_assertions.sv ====
/* assertions on the check port and the status fields.
   assumes a bind onto the register block. */
`timescale 1ns/1ns
module flash_status_checker (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       chkValid,
  input wire logic [8:0] chkFirst,
  input wire logic       chkDone,
  input wire logic       chkReject,
  input wire logic [3:0] protectLevel,
  input wire logic       topBottomSelect,
  input wire logic       complementProtect,
  input wire logic       statusWriteLock,
  input wire logic [2:0] securityLocks,
  input wire logic       protectSchemeSelect
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic plainMode; // region mode without complement
  assign plainMode = !complementProtect && !protectSchemeSelect;
  a_done_follows: assert property (chkValid |=> chkDone) else $error("no done");
  a_done_cause: assert property (chkDone |-> $past(chkValid)) else $error("stray done");
  a_level_zero:
    assert property (chkValid && protectLevel == 4'h0 && plainMode |=> !chkReject) else $error("zero rejects");
  a_top_one:
    assert property (chkValid && protectLevel == 4'h1 && !topBottomSelect && plainMode && chkFirst == 9'h1ff
      |=> chkReject) else $error("top block open");
  a_level_full:
    assert property (chkValid && protectLevel >= 4'ha && plainMode |=> chkReject) else $error("full open");
  a_cmp_zero:
    assert property (chkValid && protectLevel == 4'h0 && complementProtect && !protectSchemeSelect
      |=> chkReject) else $error("complement open");
  a_scheme_all: assert property (chkValid && protectSchemeSelect |=> chkReject) else $error("scheme open");
  a_lock_sticks: assert property (statusWriteLock |=> statusWriteLock) else $error("lock dropped");
  a_lock_freeze:
    assert property (statusWriteLock |=> $stable(protectLevel) && $stable(topBottomSelect)) else $error("locked");
  a_seclock_keep:
    assert property (1'b1 |=> (securityLocks & $past(securityLocks)) == $past(securityLocks)) else $error("cleared");
endmodule : flash_status_checker

// ==== spi_host_model.sv ====
/* spi host model: mode 0 frames, msb first, clock only in frames.
   assumes status reads answer after the opcode byte. */
`timescale 1ns/1ns
module spi_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic misoOe
);
  logic [7:0] rdData; // last byte read
  event       rdEv;   // read finished
  initial {sclk, csN, mosi} = 3'h2;
  // one byte out and one in, 32 ns per bit
  task automatic shift(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #16 sclk = 1'b1;
      r[i] = misoOe ? miso : 1'bx;
      #16 sclk = 1'b0;
    end
  endtask : shift
  // whole frame, then a gap well above three core clocks
  task automatic frame(input logic [7:0] op, input logic [7:0] d, input logic two, input logic rd);
    logic [7:0] r;
    #3 csN = 1'b0;
    #16 shift(op, r);
    if (two) shift(d, r);
    if (rd) shift(8'h00, r);
    #16 csN = 1'b1;
    mosi = ~mosi; // released line shows no stale level
    if (rd) begin
      rdData = r; // bench alone judges reserved bits
      ->rdEv;
    end
    #100;
  endtask : frame
endmodule : spi_host_model

// ==== flash_status_protect_regs_tb.sv ====
/* self-checking bench: host model on the link, bench on the check port.
   assumes the package opcodes and field layout. */
`timescale 1ns/1ns
module flash_status_protect_regs_tb;
  import flash_status_pkg::*;
  logic clock, reset, sclk, csN, mosi, miso, misoOe, chkValid, chkDone, chkReject;
  logic [8:0] chkFirst, chkLast;
  logic [15:0] seed;
  int n_errors, checked;
  logic expQ[$];
  logic [7:0] rdQ[$];
  flash_status_protect_regs uut (.clock(clock), .reset(reset), .sclk(sclk), .csN(csN), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .chkValid(chkValid), .chkFirst(chkFirst), .chkLast(chkLast),
    .chkDone(chkDone), .chkReject(chkReject), .protectLevel(), .topBottomSelect(), .complementProtect(),
    .statusWriteLock(), .pausedOpFlag(), .securityLocks(), .currentAddrWidth(), .powerupAddrWidth(),
    .protectSchemeSelect(), .outputStrength(), .writeLatch());
  spi_host_model host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic logic rej(input logic [3:0] l, input logic t, c, s, input logic [8:0] f, la);
    int n, lo, hi;
    n = (l == 0) ? 0 : (l >= 10) ? 512 : (1 << (l - 1));
    lo = t ? 0 : 512 - n;
    hi = t ? n - 1 : 511;
    return s | (c ? !(n > 0 && f >= lo && la <= hi) : (n > 0 && f <= hi && la >= lo));
  endfunction : rej
  task automatic cmp8(input string nm, input logic [7:0] e, g);
    checked++;
    if (e !== g) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic rd(input logic [7:0] op, e);
    rdQ.push_back(e);
    host.frame(op, 8'h00, 1'b0, 1'b1);
  endtask : rd
  task automatic wr(input logic [7:0] op, d, pre);
    host.frame(pre, 8'h00, 1'b0, 1'b0);
    host.frame(op, d, 1'b1, 1'b0);
  endtask : wr
  // back-to-back checks: both end blocks, then random ranges
  task automatic chk(input logic [3:0] l, input logic t, c, s);
    logic [8:0] x, y;
    for (int j = 0; j < 5; j++) begin
      seed = lfsr(seed);
      x = (j == 0) ? 9'h1ff : (j == 1) ? 9'h000 : seed[8:0];
      y = (j < 2) ? x : seed[15:7];
      @(negedge clock);
      chkValid = 1'b1;
      chkFirst = (x < y) ? x : y;
      chkLast = (x < y) ? y : x;
      expQ.push_back(rej(l, t, c, s, chkFirst, chkLast));
    end
    @(negedge clock) chkValid = 1'b0;
  endtask : chk
  always @(negedge clock) if (chkDone === 1'b1) cmp8("chkReject", expQ.size() ? {7'h0, expQ.pop_front()} : 8'hxx,
    {7'h0, chkReject});
  always @(host.rdEv) cmp8("status", rdQ.size() ? rdQ.pop_front() : 8'hxx, host.rdData);
  initial begin
    repeat (100000) @(posedge clock);
    cmp8("watchdog", 8'h00, 8'h01);
    test_done();
  end
  initial begin
    {reset, chkValid, chkFirst, chkLast} = 20'h8_0000;
    {n_errors, checked} = '0;
    seed = 16'h4bb7;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    rd(OP_READ_SR1, 8'h00);
    rd(OP_READ_SR2, 8'h00);
    rd(OP_READ_SR3, 8'h60);
    host.frame(OP_WRITE_SR1, 8'he4, 1'b1, 1'b0);
    rd(OP_READ_SR1, 8'h00);
    wr(OP_WRITE_SR1, 8'he7, OP_WRITE_ENABLE);
    rd(OP_READ_SR1, 8'h64);
    $display("test write gating done");
    for (int i = 0; i < 64; i++) begin
      wr(OP_WRITE_SR1, {1'b0, i[4], i[3:0], 2'b00}, OP_WRITE_ENABLE);
      wr(OP_WRITE_SR2, {1'b0, i[5], 6'h00}, OP_WRITE_ENABLE);
      chk(i[3:0], i[4], i[5], 1'b0);
    end
    $display("test protection map done");
    host.frame(OP_SUSPEND, 8'h00, 1'b0, 1'b0);
    rd(OP_READ_SR2, 8'hc0);
    host.frame(OP_RESUME, 8'h00, 1'b0, 1'b0);
    rd(OP_READ_SR2, 8'h40);
    wr(OP_WRITE_SR3, 8'hff, OP_WRITE_ENABLE);
    rd(OP_READ_SR3, 8'h66);
    chk(4'hf, 1'b1, 1'b1, 1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(OP_WRITE_SR3, {1'b0, s[1:0], 5'h00}, OP_VOLATILE_ENABLE);
      rd(OP_READ_SR3, {1'b0, s[1:0], 5'h02});
    end
    host.frame(OP_ENTER_WIDE, 8'h00, 1'b0, 1'b0);
    rd(OP_READ_SR3, 8'h63);
    wr(OP_WRITE_SR2, 8'h08, OP_WRITE_ENABLE);
    wr(OP_WRITE_SR2, 8'h00, OP_WRITE_ENABLE);
    rd(OP_READ_SR2, 8'h08);
    wr(OP_WRITE_SR2, 8'h01, OP_WRITE_ENABLE);
    wr(OP_WRITE_SR1, 8'h3c, OP_WRITE_ENABLE);
    rd(OP_READ_SR1, 8'h7e);
    rd(OP_READ_SR2, 8'h09);
    $display("test config and lock done");
    reset = 1'b1;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    rd(OP_READ_SR2, 8'h00);
    wr(OP_PERMANENT_LOCK, 8'h00, OP_WRITE_ENABLE);
    rd(OP_READ_SR2, 8'h01);
    wr(OP_WRITE_SR1, 8'h04, OP_WRITE_ENABLE);
    rd(OP_READ_SR1, 8'h02);
    $display("test reset and permanent lock done");
    cmp8("pending", 8'h00, 8'(expQ.size() + rdQ.size()));
    test_done();
  end
endmodule : flash_status_protect_regs_tb
bind flash_status_protect_regs flash_status_checker chk (.clock(clock), .reset(reset), .chkValid(chkValid),
  .chkFirst(chkFirst), .chkDone(chkDone), .chkReject(chkReject), .protectLevel(protectLevel),
  .topBottomSelect(topBottomSelect), .complementProtect(complementProtect), .statusWriteLock(statusWriteLock),
  .securityLocks(securityLocks), .protectSchemeSelect(protectSchemeSelect));
